// >>> aps_irq_pkg.sv
// Constants for the overflow/cell interrupt enables and the APS byte registers.
// Assumes an APB slave with 32-bit data, registers at four times their index.

package aps_irq_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_EVENT_EN   = 8'h2E;
    localparam logic [7:0] IDX_OVFL_EN    = 8'h2F;
    localparam logic [7:0] IDX_CELL_EN    = 8'h30;
    localparam logic [7:0] IDX_APS_TX     = 8'h32;
    localparam logic [7:0] IDX_APS_RX     = 8'h33;
    localparam logic [7:0] IDX_EVENT_STAT = 8'h39;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int          REG_W          = 16;
    localparam int          BYTE_ONE_LSB   = 8;
    localparam int          BYTE_TWO_LSB   = 0;
    localparam int          APS_EVENT_BIT  = 12;
    localparam logic [15:0] EVENT_EN_MASK  = 16'h9FFF;
    localparam logic [15:0] APS_EVENT_MASK = 16'h1000;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_ENABLE = 16'h0000;
    localparam logic [15:0] RST_APS    = 16'h0000;

endpackage

// >>> aps_irq_regs.sv
// Overflow and cell interrupt enables, APS transmit/receive bytes, APS change
// event and the shared interrupt output, reached over APB.
// Assumes status vectors and received overhead bytes arrive on clk_sys.

`timescale 1ns/1ps

module aps_irq_regs (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // status sources
    input  wire logic [15:0] ovflStatus,
    input  wire logic [15:0] cellStatus,
    input  wire logic [15:0] eventStatus,
    input  wire logic        lineIrqReq,
    // overhead bytes
    input  wire logic [7:0]  apsRxByteOne,
    input  wire logic [7:0]  apsRxByteTwo,
    input  wire logic        apsRxValid,
    output logic      [7:0]  apsTxByteOne,
    output logic      [7:0]  apsTxByteTwo,
    // shared interrupt
    output logic             statInt
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ovflEn;
        logic [15:0] cellEn;
        logic [15:0] eventEn;
        logic [15:0] apsTx;
        logic [15:0] apsRx;
        logic        apsChg;
        logic [31:0] rdata;
        logic        slverr;
        logic        irq;
    } state_t;

    state_t state_q;
    state_t state_d;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic hitIdx(input logic [7:0] addr, input logic [7:0] idx);
        hitIdx = (addr[1:0] == 2'b00) && (addr[7:2] == idx[5:0]);
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        logic hit;
        hit = 1'b0;
        if (addr[1:0] == 2'b00) begin
            case (addr[7:2])
                aps_irq_pkg::IDX_EVENT_EN[5:0],
                aps_irq_pkg::IDX_OVFL_EN[5:0],
                aps_irq_pkg::IDX_CELL_EN[5:0],
                aps_irq_pkg::IDX_APS_TX[5:0],
                aps_irq_pkg::IDX_APS_RX[5:0],
                aps_irq_pkg::IDX_EVENT_STAT[5:0]: begin
                    hit = 1'b1;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end
        mapped = hit;
    endfunction

    // register contents as seen by a read; misaligned reads give zero
    function automatic logic [15:0] readBack(input logic [7:0] addr, input state_t s);
        logic [15:0] word;
        word = 16'h0000;
        if (addr[1:0] == 2'b00) begin
            case (addr[7:2])
                aps_irq_pkg::IDX_OVFL_EN[5:0]: begin
                    word = s.ovflEn;
                end
                aps_irq_pkg::IDX_CELL_EN[5:0]: begin
                    word = s.cellEn;
                end
                aps_irq_pkg::IDX_EVENT_EN[5:0]: begin
                    word = s.eventEn;
                end
                aps_irq_pkg::IDX_APS_TX[5:0]: begin
                    word = s.apsTx;
                end
                aps_irq_pkg::IDX_APS_RX[5:0]: begin
                    word = s.apsRx;
                end
                aps_irq_pkg::IDX_EVENT_STAT[5:0]: begin
                    word[aps_irq_pkg::APS_EVENT_BIT] = s.apsChg;
                end
                default: begin
                    word = 16'h0000;
                end
            endcase
        end
        readBack = word;
    endfunction

    // ------------------------------------------------------------------
    // interrupt gating
    // ------------------------------------------------------------------
    logic [15:0] ovflGated;
    logic [15:0] cellGated;
    logic [15:0] eventGated;
    logic [15:0] eventSrc;
    logic [9:1]  lineCntOvfl;
    logic        idleCellOvfl;
    logic        unmatchedOvfl;
    logic        flowCtrlOvfl;
    logic        payLenOvfl;
    logic        payCrcOvfl;
    logic        uncorrHecOvfl;
    logic        corrHecOvfl;
    logic [3:0]  txCellOvfl;
    logic [3:0]  rxCellOvfl;
    logic [3:0]  hdrMatch;
    logic [3:0]  cellSent;
    logic        ovflAny;
    logic        cellAny;
    logic        eventAny;
    logic        lineAny;

    // line/phy counters 9..1 sit on enable bits 15..7
    for (genvar n = 1; n <= 9; n++) begin : g_line_cnt
        assign lineCntOvfl[n] = ovflStatus[n + 6] & state_q.ovflEn[n + 6];
    end

    // cell layer counters, one enable bit each
    assign idleCellOvfl  = ovflStatus[6] & state_q.ovflEn[6];
    assign unmatchedOvfl = ovflStatus[5] & state_q.ovflEn[5];
    assign flowCtrlOvfl  = ovflStatus[4] & state_q.ovflEn[4];
    assign payLenOvfl    = ovflStatus[3] & state_q.ovflEn[3];
    assign payCrcOvfl    = ovflStatus[2] & state_q.ovflEn[2];
    assign uncorrHecOvfl = ovflStatus[1] & state_q.ovflEn[1];
    assign corrHecOvfl   = ovflStatus[0] & state_q.ovflEn[0];

    assign ovflGated = {lineCntOvfl, idleCellOvfl, unmatchedOvfl, flowCtrlOvfl,
                        payLenOvfl, payCrcOvfl, uncorrHecOvfl, corrHecOvfl};

    // four ports, four condition groups of the cell status
    for (genvar p = 0; p < 4; p++) begin : g_port
        assign txCellOvfl[p] = cellStatus[p + 12] & state_q.cellEn[p + 12];
        assign rxCellOvfl[p] = cellStatus[p + 8] & state_q.cellEn[p + 8];
        assign hdrMatch[p]   = cellStatus[p + 4] & state_q.cellEn[p + 4];
        assign cellSent[p]   = cellStatus[p] & state_q.cellEn[p];
    end

    assign cellGated = {txCellOvfl, rxCellOvfl, hdrMatch, cellSent};

    // aps change replaces the external bit 12
    assign eventSrc   = (eventStatus & ~aps_irq_pkg::APS_EVENT_MASK)
                      | (state_q.apsChg ? aps_irq_pkg::APS_EVENT_MASK : 16'h0000);
    assign eventGated = eventSrc & state_q.eventEn;

    // ------------------------------------------------------------------
    // interrupt groups
    // ------------------------------------------------------------------
    assign ovflAny  = |ovflGated;
    assign cellAny  = |cellGated;
    assign eventAny = |eventGated;
    assign lineAny  = lineIrqReq;

    // ------------------------------------------------------------------
    // bus phases
    // ------------------------------------------------------------------
    logic        setup;
    logic        wrAccess;
    logic [15:0] wdata;
    logic [15:0] rxNew;

    assign setup    = psel && !penable;
    assign wrAccess = psel && penable && pwrite;
    assign wdata    = pwdata[15:0];
    assign rxNew    = {apsRxByteOne, apsRxByteTwo};

    // ------------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------------
    logic wrOvflEn;
    logic wrCellEn;
    logic wrEventEn;
    logic wrApsTx;
    logic clrApsChg;

    assign wrOvflEn  = wrAccess && hitIdx(paddr, aps_irq_pkg::IDX_OVFL_EN);
    assign wrCellEn  = wrAccess && hitIdx(paddr, aps_irq_pkg::IDX_CELL_EN);
    assign wrEventEn = wrAccess && hitIdx(paddr, aps_irq_pkg::IDX_EVENT_EN);
    assign wrApsTx   = wrAccess && hitIdx(paddr, aps_irq_pkg::IDX_APS_TX);
    assign clrApsChg = wrAccess && hitIdx(paddr, aps_irq_pkg::IDX_EVENT_STAT)
                     && wdata[aps_irq_pkg::APS_EVENT_BIT];

    // ------------------------------------------------------------------
    // aps receive change
    // ------------------------------------------------------------------
    logic rxDiff;
    logic apsSet;

    assign rxDiff = (rxNew != state_q.apsRx);
    assign apsSet = apsRxValid && rxDiff;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;

        // register writes take effect in the access phase
        if (wrOvflEn) begin
            state_d.ovflEn = wdata;
        end
        if (wrCellEn) begin
            state_d.cellEn = wdata;
        end
        if (wrEventEn) begin
            state_d.eventEn = wdata & aps_irq_pkg::EVENT_EN_MASK;
        end
        if (wrApsTx) begin
            state_d.apsTx = wdata;
        end
        // write one to clear the aps change flag
        if (clrApsChg) begin
            state_d.apsChg = 1'b0;
        end

        // capture received bytes; a new change wins over a clear
        if (apsRxValid) begin
            state_d.apsRx = rxNew;
        end
        if (apsSet) begin
            state_d.apsChg = 1'b1;
        end

        // read data and error prepared in the setup phase
        if (setup) begin
            state_d.rdata  = 32'h0000_0000;
            state_d.slverr = !mapped(paddr);
            if (!pwrite) begin
                state_d.rdata[15:0] = readBack(paddr, state_q);
            end
        end

        // one shared line for every enabled pair and the ungated line request
        state_d.irq = ovflAny || cellAny || eventAny || lineAny;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q.ovflEn  <= aps_irq_pkg::RST_ENABLE;
            state_q.cellEn  <= aps_irq_pkg::RST_ENABLE;
            state_q.eventEn <= aps_irq_pkg::RST_ENABLE;
            state_q.apsTx   <= aps_irq_pkg::RST_APS;
            state_q.apsRx   <= aps_irq_pkg::RST_APS;
            state_q.apsChg  <= 1'b0;
            state_q.rdata   <= 32'h0000_0000;
            state_q.slverr  <= 1'b0;
            state_q.irq     <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // apb outputs
    // ------------------------------------------------------------------
    // zero wait states: every access phase completes at once
    assign prdata       = state_q.rdata;
    assign pready       = 1'b1;
    assign pslverr      = state_q.slverr && psel && penable;

    // ------------------------------------------------------------------
    // overhead bytes
    // ------------------------------------------------------------------
    assign apsTxByteOne = state_q.apsTx[15:8];
    assign apsTxByteTwo = state_q.apsTx[7:0];

    // ------------------------------------------------------------------
    // shared interrupt
    // ------------------------------------------------------------------
    assign statInt      = state_q.irq;

endmodule

// >>> aps_irq_monitor.sv
// Port checks for the enable, APS byte and shared interrupt block.
// Assumes APB byte address is four times the register index.
`timescale 1ns/1ps
module aps_irq_monitor (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] ovflStatus,
    input wire logic [15:0] cellStatus,
    input wire logic        lineIrqReq,
    input wire logic [7:0]  apsTxByteOne,
    input wire logic [7:0]  apsTxByteTwo,
    input wire logic        statInt
);
    logic [15:0] ovflEn_q;
    logic [15:0] cellEn_q;
    wire         wrAcc = psel && penable && pwrite;
    // mirror of the two enables
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ovflEn_q <= 16'h0000;
            cellEn_q <= 16'h0000;
        end else if (wrAcc && paddr == 8'hBC) begin
            ovflEn_q <= pwdata[15:0];
        end else if (wrAcc && paddr == 8'hC0) begin
            cellEn_q <= pwdata[15:0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence txWrite;
        wrAcc && paddr == 8'hC8;
    endsequence
    sequence txLoaded;
        apsTxByteOne == $past(pwdata[15:8]) && apsTxByteTwo == $past(pwdata[7:0]);
    endsequence
    a_ovfl_gate: assert property ((ovflStatus & ovflEn_q) != 16'h0000 |=> statInt)
        else $error("overflow cause without interrupt");
    a_cell_gate: assert property ((cellStatus & cellEn_q) != 16'h0000 |=> statInt)
        else $error("cell cause without interrupt");
    a_line_share: assert property (lineIrqReq |=> statInt)
        else $error("line request not on interrupt");
    a_tx_load: assert property (txWrite |=> txLoaded)
        else $error("tx bytes not loaded");
    a_tx_hold: assert property (!(wrAcc && paddr == 8'hC8) |=> $stable({apsTxByteOne, apsTxByteTwo}))
        else $error("tx bytes moved");
    a_ready_high: assert property (psel && penable |-> pready)
        else $error("no ready in access");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    a_err_align: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access accepted");
    a_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read half set");
endmodule

// >>> aps_irq_regs_test.sv
// Directed bench for the enable, APS byte and shared interrupt block.
// Assumes zero-wait APB slave and registered interrupt output.
`timescale 1ns/1ps
module overflow_cell_irq_enable_aps_bytes_test;
    logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
    logic        lineIrqReq, apsRxValid, statInt;
    logic [7:0]  paddr, apsRxByteOne, apsRxByteTwo, apsTxByteOne, apsTxByteTwo;
    logic [31:0] pwdata, prdata;
    logic [15:0] ovflStatus, cellStatus, eventStatus;
    int          fails, checked, cyc;
    aps_irq_regs dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ovflStatus, .cellStatus, .eventStatus, .lineIrqReq,
        .apsRxByteOne, .apsRxByteTwo, .apsRxValid, .apsTxByteOne, .apsTxByteTwo, .statInt);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic eExp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 16'h0000, r, e);
        chk(r, {16'h0000, exp});
        chk({31'h0, e}, {31'h0, eExp});
    endtask
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic test_reset;
        rd(8'hBC, 16'h0000, 1'b0); rd(8'hC0, 16'h0000, 1'b0);
        rd(8'hC8, 16'h0000, 1'b0); rd(8'hCC, 16'h0000, 1'b0);
        chk({15'h0, statInt, apsTxByteOne, apsTxByteTwo}, 32'h0);
        $display("reset values done");
    endtask
    task automatic test_tx;
        wr(8'hC8, 16'hA55A);
        #1;
        chk({24'h0, apsTxByteOne}, 32'hA5);
        chk({24'h0, apsTxByteTwo}, 32'h5A);
        rd(8'hC8, 16'hA55A, 1'b0);
        $display("tx aps done");
    endtask
    task automatic test_enables;
        for (int i = 0; i < 16; i++) begin
            wr(8'hBC, 16'h0001 << i);
            wr(8'hC0, 16'h8000 >> i);
            @(posedge clk_sys);
            ovflStatus <= ~(16'h0001 << i);
            cellStatus <= ~(16'h8000 >> i);
            settle;
            chk({31'h0, statInt}, 32'h0);
            @(posedge clk_sys);
            ovflStatus <= 16'h0001 << i;
            settle;
            chk({31'h0, statInt}, 32'h1);
            @(posedge clk_sys);
            ovflStatus <= 16'h0000;
            cellStatus <= 16'h8000 >> i;
            settle;
            chk({31'h0, statInt}, 32'h1);
            @(posedge clk_sys);
            cellStatus <= 16'h0000;
        end
        rd(8'hBC, 16'h8000, 1'b0); rd(8'hC0, 16'h0001, 1'b0);
        $display("enables done");
    endtask
    task automatic test_errors;
        wr(8'h04, 16'h1234);
        rd(8'h04, 16'h0000, 1'b1);
        rd(8'hBD, 16'h0000, 1'b1);
        $display("unmapped done");
    endtask
    task automatic test_line;
        @(posedge clk_sys);
        lineIrqReq <= 1'b1;
        settle;
        chk({31'h0, statInt}, 32'h1);
        @(posedge clk_sys);
        lineIrqReq <= 1'b0;
        settle;
        chk({31'h0, statInt}, 32'h0);
        $display("line share done");
    endtask
    task automatic rxPair(input logic [7:0] k1, input logic [7:0] k2);
        @(posedge clk_sys);
        apsRxByteOne <= k1; apsRxByteTwo <= k2; apsRxValid <= 1'b1;
        @(posedge clk_sys);
        apsRxValid <= 1'b0;
        settle;
    endtask
    task automatic test_rx;
        wr(8'hB8, 16'h1000);
        rxPair(8'h12, 8'h34);
        chk({31'h0, statInt}, 32'h1);
        rd(8'hCC, 16'h1234, 1'b0);
        rd(8'hE4, 16'h1000, 1'b0);
        wr(8'hCC, 16'hFFFF);
        rd(8'hCC, 16'h1234, 1'b0);
        wr(8'hE4, 16'h1000);
        settle;
        chk({31'h0, statInt}, 32'h0);
        rxPair(8'h12, 8'h34);
        rd(8'hE4, 16'h0000, 1'b0);
        rxPair(8'h12, 8'h35);
        rd(8'hE4, 16'h1000, 1'b0);
        $display("rx aps done");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            tally_and_finish;
        end
    end
    initial begin
        {rst_b, psel, penable, pwrite, lineIrqReq, apsRxValid} = 6'h0;
        {paddr, pwdata, apsRxByteOne, apsRxByteTwo} = 56'h0;
        {ovflStatus, cellStatus, eventStatus} = 48'h0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        test_reset; test_tx; test_enables; test_errors; test_line; test_rx;
        tally_and_finish;
    end
endmodule
bind aps_irq_regs aps_irq_monitor mon (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ovflStatus, .cellStatus, .lineIrqReq,
    .apsTxByteOne, .apsTxByteTwo, .statInt);
